// *** design/amfrm_fault_report.sv ***
/*
 * Fault and warning report logic of a stereo amplifier: status flags, pin
 * masks, latch enables, recovery and current limit controls, fault clear.
 * Assumes a control port decoder that presents single-cycle register read
 * and write strobes with an 8-bit offset, and detector inputs synchronous
 * to clock_in.
 */
`timescale 1ns/1ps

// Summary of operation
// - Warning bits 5,4 show left/right current warnings
// - Warning bits 3,2 show 146C and 134C levels
// - Warning bits 1,0 show 122C and 112C levels
// - Mask bit 7 hides thermal shutdown from pin
// - Mask bits 6,5 hide digital supply faults
// - Mask bit 4 hides clock fault; bit 3 zero
// - Mask bit 2 hides power supply range faults
// - Mask bits 1,0 hide offset and overcurrent faults
// - Latch bit 7 holds current limit faults
// - Latch bit 6 holds current limit warnings
// - Latch bit 5 holds clock faults
// - Latch bit 4 holds thermal shutdown faults
// - Latch bit 3 holds thermal warnings
// - Latch register bit 2 hides thermal warnings
// - Latch register bit 1 hides current warnings
// - Latch register bit 0 hides current faults
// - Latch register resets to f8
// - Misc bit 7 latches clock detection status
// - Misc bit 4 enables thermal auto recovery
// - Current limit bits 2,1,0 enable limit, warning, fault
// - Writing clear bit 7 clears latched faults
// - Fault sets flag, outputs high impedance, pin
module amfrm_fault_report
#(
    parameter int ADDR_WIDTH = 8
)
(
    input  wire logic                  clock_in,
    input  wire logic                  arst_n_in,
    input  wire logic [ADDR_WIDTH-1:0] reg_addr_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    input  wire logic [7:0]            reg_wdata_in,
    input  wire logic                  out_overcurrent_in,
    input  wire logic                  out_offset_error_in,
    input  wire logic                  power_stage_supply_low_in,
    input  wire logic                  power_stage_supply_high_in,
    input  wire logic                  clock_error_in,
    input  wire logic                  digital_supply_high_in,
    input  wire logic                  digital_supply_low_in,
    input  wire logic                  thermal_shutdown_in,
    input  wire logic                  cycle_current_limit_error_in,
    input  wire logic                  right_current_limit_warning_in,
    input  wire logic                  left_current_limit_warning_in,
    input  wire logic [3:0]            overtemp_warn_level_in,
    input  wire logic                  clock_detect_in,
    output      logic [7:0]            reg_rdata_out,
    output      logic                  fault_report_n_out,
    output      logic                  output_hiz_out,
    output      logic                  clock_detect_state_out,
    output      logic                  current_limit_on_out
);

    if (ADDR_WIDTH < 7 || ADDR_WIDTH > 8)
    begin : g_addr_width_check
        $error("amfrm_fault_report: ADDR_WIDTH must be 7 or 8");
    end

    typedef struct packed
    {
        logic [7:0] pin_mask;
        logic [7:0] latch_ctl;
        logic [7:0] misc;
        logic [7:0] ccl;
        logic [6:0] clr_rsvd;
        logic       clear_pulse;
        logic [7:0] rdata;
        logic       fault_n;
        logic       hiz;
        logic       det_state;
        logic       ccl_on;
    } amfrm_state_t;

    amfrm_state_t st_reg;
    amfrm_state_t st_next;

    logic [amfrm_pkg::NUM_CLASSES-1:0] cond_vec;
    logic [amfrm_pkg::NUM_CLASSES-1:0] hold_vec;
    logic [amfrm_pkg::NUM_CLASSES-1:0] hide_vec;
    logic [amfrm_pkg::NUM_CLASSES-1:0] flags;
    logic [7:0]                        warn_value;
    logic [7:0]                        addr8;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign addr8 = 8'(reg_addr_in);

    // Live conditions, current limit reports gated by their enables
    always_comb
    begin
        cond_vec = '0;
        cond_vec[amfrm_pkg::CLS_OUT_OC]     = out_overcurrent_in;
        cond_vec[amfrm_pkg::CLS_OUT_DC]     = out_offset_error_in;
        cond_vec[amfrm_pkg::CLS_PWR_LOW]    = power_stage_supply_low_in;
        cond_vec[amfrm_pkg::CLS_PWR_HIGH]   = power_stage_supply_high_in;
        cond_vec[amfrm_pkg::CLS_CLOCK]      = clock_error_in;
        cond_vec[amfrm_pkg::CLS_DIG_HIGH]   = digital_supply_high_in;
        cond_vec[amfrm_pkg::CLS_DIG_LOW]    = digital_supply_low_in;
        cond_vec[amfrm_pkg::CLS_THERMAL_SD] = thermal_shutdown_in;
        cond_vec[amfrm_pkg::CLS_CCL_ERROR]  = cycle_current_limit_error_in
            & st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_ON]
            & st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_ERROR_ON];
        cond_vec[amfrm_pkg::CLS_CCLW_RIGHT] = right_current_limit_warning_in
            & st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_ON]
            & st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_WARNING_ON];
        cond_vec[amfrm_pkg::CLS_CCLW_LEFT]  = left_current_limit_warning_in
            & st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_ON]
            & st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_WARNING_ON];
        cond_vec[amfrm_pkg::CLS_THW_FOUR:amfrm_pkg::CLS_THW_ONE] = overtemp_warn_level_in;
    end

    // Latch enables; output and supply faults always hold until cleared
    always_comb
    begin
        hold_vec = '1;
        hold_vec[amfrm_pkg::CLS_CCL_ERROR]  =
            st_reg.latch_ctl[amfrm_pkg::HOLD_CURRENT_LIMIT_ERROR];
        hold_vec[amfrm_pkg::CLS_CCLW_RIGHT] =
            st_reg.latch_ctl[amfrm_pkg::HOLD_CURRENT_LIMIT_WARNING];
        hold_vec[amfrm_pkg::CLS_CCLW_LEFT]  =
            st_reg.latch_ctl[amfrm_pkg::HOLD_CURRENT_LIMIT_WARNING];
        hold_vec[amfrm_pkg::CLS_CLOCK]      =
            st_reg.latch_ctl[amfrm_pkg::HOLD_CLOCK_ERROR];
        // Auto recovery lets thermal shutdown follow the live condition
        hold_vec[amfrm_pkg::CLS_THERMAL_SD] =
            st_reg.latch_ctl[amfrm_pkg::HOLD_THERMAL_SHUTDOWN]
            & ~st_reg.misc[amfrm_pkg::THERMAL_AUTO_RECOVERY_ON];
        hold_vec[amfrm_pkg::CLS_THW_FOUR:amfrm_pkg::CLS_THW_ONE] =
            {4{st_reg.latch_ctl[amfrm_pkg::HOLD_THERMAL_WARNING]}};
    end

    // Pin masks
    always_comb
    begin
        hide_vec = '0;
        hide_vec[amfrm_pkg::CLS_THERMAL_SD] =
            st_reg.pin_mask[amfrm_pkg::HIDE_THERMAL_SHUTDOWN];
        hide_vec[amfrm_pkg::CLS_DIG_LOW]    =
            st_reg.pin_mask[amfrm_pkg::HIDE_DIGITAL_SUPPLY_LOW];
        hide_vec[amfrm_pkg::CLS_DIG_HIGH]   =
            st_reg.pin_mask[amfrm_pkg::HIDE_DIGITAL_SUPPLY_HIGH];
        hide_vec[amfrm_pkg::CLS_CLOCK]      =
            st_reg.pin_mask[amfrm_pkg::HIDE_CLOCK_ERROR];
        hide_vec[amfrm_pkg::CLS_PWR_LOW]    =
            st_reg.pin_mask[amfrm_pkg::HIDE_POWER_SUPPLY_RANGE];
        hide_vec[amfrm_pkg::CLS_PWR_HIGH]   =
            st_reg.pin_mask[amfrm_pkg::HIDE_POWER_SUPPLY_RANGE];
        hide_vec[amfrm_pkg::CLS_OUT_DC]     =
            st_reg.pin_mask[amfrm_pkg::HIDE_OUTPUT_OFFSET_ERROR];
        hide_vec[amfrm_pkg::CLS_OUT_OC]     =
            st_reg.pin_mask[amfrm_pkg::HIDE_OUTPUT_OVERCURRENT];
        hide_vec[amfrm_pkg::CLS_CCL_ERROR]  =
            st_reg.latch_ctl[amfrm_pkg::HIDE_CURRENT_LIMIT_ERROR];
        hide_vec[amfrm_pkg::CLS_CCLW_RIGHT] =
            st_reg.latch_ctl[amfrm_pkg::HIDE_CURRENT_LIMIT_WARNING];
        hide_vec[amfrm_pkg::CLS_CCLW_LEFT]  =
            st_reg.latch_ctl[amfrm_pkg::HIDE_CURRENT_LIMIT_WARNING];
        hide_vec[amfrm_pkg::CLS_THW_FOUR:amfrm_pkg::CLS_THW_ONE] =
            {4{st_reg.latch_ctl[amfrm_pkg::HIDE_THERMAL_WARNING]}};
    end

    // Status flags set regardless of the pin masks
    for (genvar g = 0; g < amfrm_pkg::NUM_CLASSES; g++)
    begin : g_cell
        amfrm_report_cell u_cell
        (
            .clock_in  (clock_in),
            .arst_n_in (arst_n_in),
            .cond_in   (cond_vec[g]),
            .hold_in   (hold_vec[g]),
            .clear_in  (st_reg.clear_pulse),
            .flag_out  (flags[g])
        );
    end

    always_comb
    begin
        warn_value = 8'h00;
        warn_value[amfrm_pkg::WARN_LEFT_CCL]  = flags[amfrm_pkg::CLS_CCLW_LEFT];
        warn_value[amfrm_pkg::WARN_RIGHT_CCL] = flags[amfrm_pkg::CLS_CCLW_RIGHT];
        warn_value[amfrm_pkg::WARN_THW_FOUR]  = flags[amfrm_pkg::CLS_THW_FOUR];
        warn_value[amfrm_pkg::WARN_THW_THREE] = flags[amfrm_pkg::CLS_THW_THREE];
        warn_value[amfrm_pkg::WARN_THW_TWO]   = flags[amfrm_pkg::CLS_THW_TWO];
        warn_value[amfrm_pkg::WARN_THW_ONE]   = flags[amfrm_pkg::CLS_THW_ONE];
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.clear_pulse = 1'b0;
        if (reg_wr_in)
        begin
            if (hit(addr8, amfrm_pkg::OFF_FAULT_PIN_MASK))
            begin
                st_next.pin_mask = reg_wdata_in;
                st_next.pin_mask[amfrm_pkg::PIN_MASK_RESERVED] = 1'b0;
            end
            else if (hit(addr8, amfrm_pkg::OFF_REPORT_LATCH))
            begin
                st_next.latch_ctl = reg_wdata_in;
            end
            else if (hit(addr8, amfrm_pkg::OFF_MISC_RECOVERY))
            begin
                st_next.misc = reg_wdata_in;
            end
            else if (hit(addr8, amfrm_pkg::OFF_CURRENT_LIMIT))
            begin
                st_next.ccl = reg_wdata_in;
            end
            else if (hit(addr8, amfrm_pkg::OFF_FAULT_CLEAR))
            begin
                st_next.clr_rsvd    = reg_wdata_in[6:0];
                st_next.clear_pulse = reg_wdata_in[amfrm_pkg::CLEAR_LATCHED_FAULTS];
            end
        end
        if (reg_rd_in)
        begin
            if (hit(addr8, amfrm_pkg::OFF_WARNING_STATUS))
            begin
                st_next.rdata = warn_value;
            end
            else if (hit(addr8, amfrm_pkg::OFF_FAULT_PIN_MASK))
            begin
                st_next.rdata = st_reg.pin_mask;
            end
            else if (hit(addr8, amfrm_pkg::OFF_REPORT_LATCH))
            begin
                st_next.rdata = st_reg.latch_ctl;
            end
            else if (hit(addr8, amfrm_pkg::OFF_MISC_RECOVERY))
            begin
                st_next.rdata = st_reg.misc;
            end
            else if (hit(addr8, amfrm_pkg::OFF_CURRENT_LIMIT))
            begin
                st_next.rdata = st_reg.ccl;
            end
            else if (hit(addr8, amfrm_pkg::OFF_FAULT_CLEAR))
            begin
                // Strobe bit reads back as zero
                st_next.rdata = {1'b0, st_reg.clr_rsvd};
            end
            else
            begin
                st_next.rdata = 8'h00;
            end
        end
        // Pin low while any unmasked report is active
        st_next.fault_n = ~|(flags & ~hide_vec);
        st_next.hiz     = |(flags & amfrm_pkg::FAULT_CLASSES);
        // Latched mode holds a detection until the fault clear strobe
        st_next.det_state = clock_detect_in | (st_reg.det_state & ~st_reg.clear_pulse
            & st_reg.misc[amfrm_pkg::HOLD_CLOCK_DETECT_STATE]);
        st_next.ccl_on = st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_ON];
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_reg.pin_mask    <= amfrm_pkg::RST_FAULT_PIN_MASK;
            st_reg.latch_ctl   <= amfrm_pkg::RST_REPORT_LATCH;
            st_reg.misc        <= amfrm_pkg::RST_MISC_RECOVERY;
            st_reg.ccl         <= amfrm_pkg::RST_CURRENT_LIMIT;
            st_reg.clr_rsvd    <= amfrm_pkg::RST_FAULT_CLEAR[6:0];
            st_reg.clear_pulse <= 1'b0;
            st_reg.rdata       <= 8'h00;
            st_reg.fault_n     <= 1'b1;
            st_reg.hiz         <= 1'b0;
            st_reg.det_state   <= 1'b0;
            st_reg.ccl_on      <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out          = st_reg.rdata;
    assign fault_report_n_out     = st_reg.fault_n;
    assign output_hiz_out         = st_reg.hiz;
    assign clock_detect_state_out = st_reg.det_state;
    assign current_limit_on_out   = st_reg.ccl_on;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    a_warn_ccl_bits: assert property (
        reg_rd_in && addr8 == amfrm_pkg::OFF_WARNING_STATUS |=>
        reg_rdata_out[7:4] == {2'b00, $past(flags[amfrm_pkg::CLS_CCLW_LEFT]),
                               $past(flags[amfrm_pkg::CLS_CCLW_RIGHT])})
        else $error("warning current bits wrong");
    a_warn_thw_high: assert property (
        reg_rd_in && addr8 == amfrm_pkg::OFF_WARNING_STATUS |=>
        reg_rdata_out[3:2] == {$past(flags[amfrm_pkg::CLS_THW_FOUR]),
                               $past(flags[amfrm_pkg::CLS_THW_THREE])})
        else $error("warning high thermal bits wrong");
    a_warn_thw_low: assert property (
        reg_rd_in && addr8 == amfrm_pkg::OFF_WARNING_STATUS |=>
        reg_rdata_out[1:0] == {$past(flags[amfrm_pkg::CLS_THW_TWO]),
                               $past(flags[amfrm_pkg::CLS_THW_ONE])})
        else $error("warning low thermal bits wrong");
    a_pin_unmasked_low: assert property (
        |(flags & ~hide_vec) |=> !fault_report_n_out)
        else $error("unmasked report missing on pin");
    a_pin_masked_high: assert property (
        !(|(flags & ~hide_vec)) |=> fault_report_n_out)
        else $error("pin low with no unmasked report");
    a_mask_rsvd_zero: assert property (
        reg_rd_in && addr8 == amfrm_pkg::OFF_FAULT_PIN_MASK |=>
        !reg_rdata_out[amfrm_pkg::PIN_MASK_RESERVED])
        else $error("reserved mask bit reads one");
    a_held_flag_stays: assert property (
        (flags & hold_vec & ~cond_vec) != '0 && !st_reg.clear_pulse |=>
        (flags & $past(flags & hold_vec)) == $past(flags & hold_vec))
        else $error("held report dropped without clear");
    a_live_flag_follows: assert property (
        hold_vec != '1 |=> ((flags ^ $past(cond_vec)) & ~$past(hold_vec)) == '0)
        else $error("unlatched report not following condition");
    a_clear_strobe: assert property (
        reg_wr_in && addr8 == amfrm_pkg::OFF_FAULT_CLEAR
        && reg_wdata_in[amfrm_pkg::CLEAR_LATCHED_FAULTS]
        |=> st_reg.clear_pulse ##1 flags == $past(cond_vec))
        else $error("fault clear did not clear");
    a_status_despite_mask: assert property (
        cond_vec != '0 |=> (flags & $past(cond_vec)) == $past(cond_vec))
        else $error("condition did not set status flag");
    a_fault_hiz: assert property (
        |(flags & amfrm_pkg::FAULT_CLASSES) |=> output_hiz_out)
        else $error("fault without high impedance");
    a_detect_live: assert property (
        !st_reg.misc[amfrm_pkg::HOLD_CLOCK_DETECT_STATE] |=>
        clock_detect_state_out == $past(clock_detect_in))
        else $error("clock detect state not live");
    a_thermal_recover: assert property (
        st_reg.misc[amfrm_pkg::THERMAL_AUTO_RECOVERY_ON] && !thermal_shutdown_in |=>
        !flags[amfrm_pkg::CLS_THERMAL_SD])
        else $error("thermal shutdown held under auto recovery");
    a_limit_gated: assert property (
        !st_reg.ccl[amfrm_pkg::CURRENT_LIMIT_ON] && st_reg.clear_pulse |=>
        !flags[amfrm_pkg::CLS_CCL_ERROR] && !flags[amfrm_pkg::CLS_CCLW_LEFT])
        else $error("current limit report while disabled");

    c_pin_asserted: cover property (fault_report_n_out ##1 !fault_report_n_out);
    c_masked_fault: cover property (flags[amfrm_pkg::CLS_THERMAL_SD]
        && hide_vec[amfrm_pkg::CLS_THERMAL_SD] && fault_report_n_out);
    c_clear_done: cover property (st_reg.clear_pulse ##1 fault_report_n_out);

endmodule

// *** pkg/amfrm_pkg.sv ***
/*
 * Constants of the amplifier fault report and mask block: register offsets,
 * field positions, reset values and the index of each report class.
 * Assumes an 8-bit register space reached through the control port decoder.
 */
package amfrm_pkg;

    // Register offsets
    localparam logic [7:0] OFF_WARNING_STATUS   = 8'h73;
    localparam logic [7:0] OFF_FAULT_PIN_MASK   = 8'h74;
    localparam logic [7:0] OFF_REPORT_LATCH     = 8'h75;
    localparam logic [7:0] OFF_MISC_RECOVERY    = 8'h76;
    localparam logic [7:0] OFF_CURRENT_LIMIT    = 8'h77;
    localparam logic [7:0] OFF_FAULT_CLEAR      = 8'h78;

    // Reset values
    localparam logic [7:0] RST_FAULT_PIN_MASK   = 8'h00;
    localparam logic [7:0] RST_REPORT_LATCH     = 8'hf8;
    localparam logic [7:0] RST_MISC_RECOVERY    = 8'h00;
    localparam logic [7:0] RST_CURRENT_LIMIT    = 8'h00;
    localparam logic [7:0] RST_FAULT_CLEAR      = 8'h00;

    // Warning status fields
    localparam int WARN_LEFT_CCL      = 5;
    localparam int WARN_RIGHT_CCL     = 4;
    localparam int WARN_THW_FOUR      = 3;
    localparam int WARN_THW_THREE     = 2;
    localparam int WARN_THW_TWO       = 1;
    localparam int WARN_THW_ONE       = 0;

    // Fault pin mask fields
    localparam int HIDE_THERMAL_SHUTDOWN     = 7;
    localparam int HIDE_DIGITAL_SUPPLY_LOW   = 6;
    localparam int HIDE_DIGITAL_SUPPLY_HIGH  = 5;
    localparam int HIDE_CLOCK_ERROR          = 4;
    localparam int PIN_MASK_RESERVED         = 3;
    localparam int HIDE_POWER_SUPPLY_RANGE   = 2;
    localparam int HIDE_OUTPUT_OFFSET_ERROR  = 1;
    localparam int HIDE_OUTPUT_OVERCURRENT   = 0;

    // Report latch and mask fields
    localparam int HOLD_CURRENT_LIMIT_ERROR   = 7;
    localparam int HOLD_CURRENT_LIMIT_WARNING = 6;
    localparam int HOLD_CLOCK_ERROR           = 5;
    localparam int HOLD_THERMAL_SHUTDOWN      = 4;
    localparam int HOLD_THERMAL_WARNING       = 3;
    localparam int HIDE_THERMAL_WARNING       = 2;
    localparam int HIDE_CURRENT_LIMIT_WARNING = 1;
    localparam int HIDE_CURRENT_LIMIT_ERROR   = 0;

    // Misc, current limit and clear fields
    localparam int HOLD_CLOCK_DETECT_STATE    = 7;
    localparam int THERMAL_AUTO_RECOVERY_ON   = 4;
    localparam int CURRENT_LIMIT_ON           = 2;
    localparam int CURRENT_LIMIT_WARNING_ON   = 1;
    localparam int CURRENT_LIMIT_ERROR_ON     = 0;
    localparam int CLEAR_LATCHED_FAULTS       = 7;

    // Report class indices
    localparam int CLS_OUT_OC       = 0;
    localparam int CLS_OUT_DC       = 1;
    localparam int CLS_PWR_LOW      = 2;
    localparam int CLS_PWR_HIGH     = 3;
    localparam int CLS_CLOCK        = 4;
    localparam int CLS_DIG_HIGH     = 5;
    localparam int CLS_DIG_LOW      = 6;
    localparam int CLS_THERMAL_SD   = 7;
    localparam int CLS_CCL_ERROR    = 8;
    localparam int CLS_CCLW_RIGHT   = 9;
    localparam int CLS_CCLW_LEFT    = 10;
    localparam int CLS_THW_ONE      = 11;
    localparam int CLS_THW_TWO      = 12;
    localparam int CLS_THW_THREE    = 13;
    localparam int CLS_THW_FOUR     = 14;
    localparam int NUM_CLASSES      = 15;

    // Classes that are faults and force the output stage to high impedance
    localparam logic [14:0] FAULT_CLASSES = 15'h01ff;

endpackage

// *** design/amfrm_report_cell.sv ***
/*
 * One report class: a status flag that either follows its live condition or
 * holds it until a clear pulse.
 * Assumes the condition input is synchronous to clock_in.
 */
`timescale 1ns/1ps

module amfrm_report_cell
(
    input  wire logic clock_in,
    input  wire logic arst_n_in,
    input  wire logic cond_in,
    input  wire logic hold_in,
    input  wire logic clear_in,
    output      logic flag_out
);

    typedef struct packed
    {
        logic flag;
    } amfrm_cell_t;

    amfrm_cell_t cell_reg;
    amfrm_cell_t cell_next;

    always_comb
    begin
        cell_next = cell_reg;
        if (hold_in)
        begin
            // New condition wins over a clear in the same cycle
            cell_next.flag = cond_in | (cell_reg.flag & ~clear_in);
        end
        else
        begin
            cell_next.flag = cond_in;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cell_reg <= '0;
        end
        else
        begin
            cell_reg <= cell_next;
        end
    end

    assign flag_out = cell_reg.flag;

endmodule

// *** tb/amfrm_host_model.sv ***
/*
 * Host model: single-byte register master on the strobe port.
 * Assumes the block samples strobes and returns read data on clock_in rising.
 */
`timescale 1ns/1ps

module amfrm_host_model
(
    input  wire logic       clock_in,
    input  wire logic [7:0] reg_rdata_in,
    output      logic [7:0] reg_addr_out,
    output      logic       reg_wr_out,
    output      logic       reg_rd_out,
    output      logic [7:0] reg_wdata_out
);
    initial {reg_addr_out, reg_wr_out, reg_rd_out, reg_wdata_out} = 18'h0;

    // One strobe cycle; address and data then show the inverse of the last value
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w,
                          output logic [7:0] q);
        @(posedge clock_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_wr_out    <= w;
        reg_rd_out    <= ~w;
        @(posedge clock_in);
        reg_wr_out    <= 1'b0;
        reg_rd_out    <= 1'b0;
        reg_addr_out  <= ~a;
        reg_wdata_out <= ~d;
        #1 q = reg_rdata_in;
    endtask
endmodule

// *** tb/amfrm_fault_report_test.sv ***
/*
 * Bench of the fault report block: host model on the register port,
 * detector conditions driven directly. Assumes a 200 MHz clock.
 */
`timescale 1ns/1ps

module amfrm_fault_report_test;
    logic        clock_in, arst_n_in, det, wr, rd, fault_n, hiz, det_st, cl_on;
    logic [10:0] cond;
    logic [3:0]  thermal_warning;
    logic [7:0]  addr, wdata, rdata, q;
    int          fail_count, comparisons;

    amfrm_fault_report u_amfrm_fault_report
    (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .out_overcurrent_in(cond[0]), .out_offset_error_in(cond[1]),
        .power_stage_supply_low_in(cond[2]), .power_stage_supply_high_in(cond[3]),
        .clock_error_in(cond[4]), .digital_supply_high_in(cond[5]),
        .digital_supply_low_in(cond[6]), .thermal_shutdown_in(cond[7]),
        .cycle_current_limit_error_in(cond[8]), .right_current_limit_warning_in(cond[9]),
        .left_current_limit_warning_in(cond[10]), .overtemp_warn_level_in(thermal_warning),
        .clock_detect_in(det), .reg_rdata_out(rdata), .fault_report_n_out(fault_n),
        .output_hiz_out(hiz), .clock_detect_state_out(det_st), .current_limit_on_out(cl_on)
    );
    amfrm_host_model u_amfrm_host_model
    (
        .clock_in(clock_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        u_amfrm_host_model.access(a, d, 1'b1, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        u_amfrm_host_model.access(a, 8'h00, 1'b0, q);
        chk(q, exp);
    endtask
    // Apply conditions, then compare {fault pin, high impedance}
    task automatic pins(input logic [10:0] c, input logic [3:0] o, input logic [1:0] e);
        @(posedge clock_in);
        cond <= c;
        thermal_warning  <= o;
        repeat (3) @(posedge clock_in);
        #1 chk({6'h0, fault_n, hiz}, {6'h0, e});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic t_regs;
        rdc(8'h75, 8'hf8);
        rdc(8'h76, 8'h00);
        rdc(8'h77, 8'h00);
        rdc(8'h74, 8'h00);
        pins(11'h000, 4'h0, 2'b10);
        wr8(8'h74, 8'hff);
        rdc(8'h74, 8'hf7);
        wr8(8'h73, 8'hff);
        rdc(8'h73, 8'h00);
        rdc(8'h40, 8'h00);
        wr8(8'h78, 8'hd5);
        rdc(8'h78, 8'h55);
        $display("register test done");
    endtask
    task automatic t_mask;
        int m [8] = '{0, 1, 2, 2, 4, 5, 6, 7};
        for (int c = 0; c < 8; c++)
        begin
            wr8(8'h74, 8'h01 << m[c]);
            pins(11'h001 << c, 4'h0, 2'b11);
            pins(11'h000, 4'h0, 2'b11);
            wr8(8'h74, 8'h00);
            pins(11'h000, 4'h0, 2'b01);
            wr8(8'h78, 8'h80);
            pins(11'h000, 4'h0, 2'b10);
        end
        $display("mask test done");
    endtask
    task automatic t_warn;
        wr8(8'h77, 8'h07);
        pins(11'h400, 4'ha, 2'b00);
        pins(11'h000, 4'h0, 2'b00);
        rdc(8'h73, 8'h2a);
        wr8(8'h75, 8'hb6);
        wr8(8'h78, 8'h80);
        pins(11'h200, 4'h5, 2'b10);
        rdc(8'h73, 8'h15);
        pins(11'h000, 4'h0, 2'b10);
        rdc(8'h73, 8'h00);
        wr8(8'h75, 8'hf8);
        $display("warning test done");
    endtask
    task automatic t_limit;
        wr8(8'h77, 8'h00);
        pins(11'h100, 4'h0, 2'b10);
        wr8(8'h77, 8'h05);
        pins(11'h100, 4'h0, 2'b01);
        chk({7'h0, cl_on}, 8'h01);
        pins(11'h000, 4'h0, 2'b01);
        wr8(8'h75, 8'hf9);
        pins(11'h000, 4'h0, 2'b11);
        wr8(8'h78, 8'h80);
        pins(11'h000, 4'h0, 2'b10);
        wr8(8'h75, 8'hf8);
        $display("limit test done");
    endtask
    task automatic t_misc;
        pins(11'h080, 4'h0, 2'b01);
        pins(11'h000, 4'h0, 2'b01);
        wr8(8'h76, 8'h10);
        pins(11'h000, 4'h0, 2'b10);
        wr8(8'h75, 8'hd8);
        pins(11'h010, 4'h0, 2'b01);
        pins(11'h000, 4'h0, 2'b10);
        wr8(8'h75, 8'hf8);
        wr8(8'h76, 8'h80);
        @(posedge clock_in);
        det <= 1'b1;
        @(posedge clock_in);
        det <= 1'b0;
        repeat (2) @(posedge clock_in);
        #1 chk({7'h0, det_st}, 8'h01);
        wr8(8'h76, 8'h00);
        repeat (2) @(posedge clock_in);
        #1 chk({7'h0, det_st}, 8'h00);
        $display("misc test done");
    endtask

    initial
    begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    initial
    begin
        #20000;
        fail_count++;
        conclude();
    end
    initial
    begin
        fail_count = 0;
        comparisons = 0;
        arst_n_in = 1'b0;
        cond = 11'h000;
        thermal_warning = 4'h0;
        det = 1'b0;
        repeat (4) @(posedge clock_in);
        arst_n_in <= 1'b1;
        t_regs();
        t_mask();
        t_warn();
        t_limit();
        t_misc();
        conclude();
    end
endmodule
